/* File: hw/lici_pkg.sv */
// Shared constants and types of the line interrupter control interlock.
// Assumes a 32-bit AXI4-Lite register bus and a byte-addressed map.
package lici_pkg;
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ARM_LIMIT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_MODES = 8'h14;
  localparam int AXI_AW = 8;

  // Control register fields and values after reset.
  localparam int CTL_TRIP_ALW = 0;
  localparam int CTL_PNL_OVR = 1;
  localparam int CTL_ETH_SEL = 2;
  localparam int CTL_POL_LSB = 4;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0077;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ARM_LIMIT_RST = 32'h0000_0000;

  // Status register fields.
  localparam int STA_SWITCH = 0;
  localparam int STA_SESSION = 1;
  localparam int STA_LEVER = 2;
  localparam int STA_ARMED = 3;
  localparam int STA_BUSY = 4;
  localparam int STA_ETH = 5;

  // Interrupt status and mask bits.
  localparam int IRQ_SREJ = 0;
  localparam int IRQ_PREJ = 1;
  localparam int IRQ_SESS_END = 2;
  localparam int IRQ_LEVER = 3;
  localparam int IRQ_ARM_EXP = 4;
  localparam int IRQ_SWITCH = 5;
  localparam int IRQ_W = 6;
  localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;

  // Positions in the pin synchroniser vector.
  localparam int SYN_SW = 0;
  localparam int SYN_PC = 1;
  localparam int SYN_LV = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_PROT_OFF = 3'h1,
    MODE_NORMAL_SINGLE = 3'h2,
    MODE_FAST_SINGLE = 3'h3,
    MODE_FAST = 3'h4
  } lici_mode_t;

  typedef enum logic [2:0] {
    KIND_TRIP = 3'h0,
    KIND_CLOSE = 3'h1,
    KIND_MODE = 3'h2,
    KIND_ARM_ON = 3'h3,
    KIND_ARM_OFF = 3'h4,
    KIND_DUMMY = 3'h5
  } lici_kind_t;

  typedef enum logic [2:0] {
    RSN_NONE = 3'h0,
    RSN_SWITCH = 3'h1,
    RSN_SESSION = 3'h2,
    RSN_LEVER = 3'h3,
    RSN_BUSY = 3'h4,
    RSN_BAD = 3'h5
  } lici_rsn_t;

  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_SEND = 2'b01,
    LK_WAIT = 2'b10
  } lici_link_st_t;

  typedef struct packed {
    lici_kind_t kind;
    logic [1:0] target;
    lici_mode_t mode;
  } lici_cmd_t;
endpackage

/* File: hw/lici_interlock.sv */
// Control interlock between supervisory, panel and PC-tool sources and the line interrupters.
// Assumes commands and the interrupter link run on aclk; switch, session and lever are pins.
`timescale 1ns/10ps
module lici_interlock #(
  parameter int NUM_LI = 3,
  parameter bit ETH_SUPPORTED = 1'b0
) (
  input wire logic aclk, // Clock, 25 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic ce, // Clock enable; state holds while low.
  input wire logic [lici_pkg::AXI_AW-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [lici_pkg::AXI_AW-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic rc_switch_pin, // Remote-control switch, high when on.
  input wire logic pc_session_pin, // Vendor PC tool in session, high.
  input wire logic [NUM_LI-1:0] lever_down_pin, // External levers, high when down.
  input wire lici_pkg::lici_cmd_t scada_cmd, // Supervisory command.
  input wire logic scada_valid, // Supervisory command valid.
  output logic scada_ready, // Supervisory command taken.
  output logic scada_ack, // Supervisory command accepted, pulse.
  output logic scada_rej, // Supervisory command rejected, pulse.
  output lici_pkg::lici_rsn_t scada_rsn, // Reason of the last rejection.
  input wire lici_pkg::lici_cmd_t panel_cmd, // Panel command.
  input wire logic panel_valid, // Panel command valid.
  output logic panel_ready, // Panel command taken.
  output logic panel_ack, // Panel command accepted, pulse.
  output logic panel_rej, // Panel command rejected, pulse.
  output lici_pkg::lici_rsn_t panel_rsn, // Reason of the last rejection.
  output lici_pkg::lici_cmd_t li_cmd, // Command to the interrupters.
  output logic li_valid, // Command to the interrupters valid.
  input wire logic li_ready, // Interrupter link took the command.
  input wire logic li_done, // Interrupter link finished the command.
  output logic [3*NUM_LI-1:0] li_mode, // Tracked protection mode per interrupter.
  output logic armed, // Forced protection arming active.
  output logic ev_fetch_en, // Event retrieval allowed.
  output logic ev_collect_all, // Collect all new events, pulse.
  output logic not_in_session, // Interrupters not in session with the unit.
  output logic serial_en, // Serial radio interface enabled.
  output logic eth_en, // Ethernet radio interface enabled.
  output logic irq // Level interrupt.
);
  import lici_pkg::*;

  localparam int SW = NUM_LI + 2;

  typedef struct packed {
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic [SW-1:0] s3;
    logic [SW-1:0] f;
    lici_mode_t [NUM_LI-1:0] mode;
    lici_mode_t [NUM_LI-1:0] saved;
    lici_link_st_t lk;
    lici_cmd_t out;
    logic armed;
    logic [31:0] atmr;
    logic [31:0] ctrl;
    logic [31:0] alim;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imsk;
    logic s_ack;
    logic s_rej;
    lici_rsn_t s_rsn;
    logic p_ack;
    logic p_rej;
    lici_rsn_t p_rsn;
    logic collect;
    logic aw_h;
    logic w_h;
    logic [AXI_AW-1:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } lici_st_t;

  lici_st_t q;
  lici_st_t d;

  // Byte-lane merge of a register write.
  function automatic logic [31:0] lici_merge(logic [31:0] old, logic [31:0] wd, logic [3:0] ws);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (ws[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Gating of one source's command, before the busy check.
  function automatic lici_rsn_t lici_gate(lici_cmd_t c, logic from_scada, logic sw, logic sess,
                                          logic lev, logic trip_alw, logic pnl_ovr);
    lici_rsn_t r;
    r = RSN_NONE;
    if (from_scada && c.kind == KIND_DUMMY) begin
      r = RSN_NONE;
    end else if (32'(c.target) >= NUM_LI || c.kind > KIND_DUMMY || c.mode > MODE_FAST) begin
      r = RSN_BAD;
    end else if (sess) begin
      r = RSN_SESSION;
    end else if (lev) begin
      r = RSN_LEVER;
    end else if (from_scada) begin
      if (!sw && !(trip_alw && c.kind == KIND_TRIP)) begin
        r = RSN_SWITCH;
      end
    end else if (c.kind > KIND_MODE) begin
      r = RSN_BAD;
    end else if (sw && !pnl_ovr) begin
      r = RSN_SWITCH;
    end
    return r;
  endfunction

  logic sw;
  logic sess;
  logic lev_any;
  logic busy;
  assign sw = q.f[SYN_SW];
  assign sess = q.f[SYN_PC];
  assign lev_any = |q.f[SYN_LV +: NUM_LI];
  assign busy = q.lk != LK_IDLE;

  // Next-state logic of the whole block.
  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [SW-1:0] nf;
    logic grabbed;
    logic aw_ok;
    logic w_ok;
    lici_rsn_t rs;
    lici_rsn_t rp;
    ev = '0;
    nf = q.f;
    grabbed = 1'b0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    rs = RSN_NONE;
    rp = RSN_NONE;
    d = q;
    d.s_ack = 1'b0;
    d.s_rej = 1'b0;
    d.p_ack = 1'b0;
    d.p_rej = 1'b0;
    d.collect = 1'b0;

    // Pins pass three flops; a change counts once the last two agree.
    d.s1 = {lever_down_pin, pc_session_pin, rc_switch_pin};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < SW; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        nf[i] = q.s3[i];
      end
    end
    d.f = nf;
    if (nf[SYN_SW] != q.f[SYN_SW]) begin
      ev[IRQ_SWITCH] = 1'b1;
    end
    if (!nf[SYN_PC] && q.f[SYN_PC]) begin
      d.collect = 1'b1;
      ev[IRQ_SESS_END] = 1'b1;
    end

    // Interrupter link handshake.
    unique case (q.lk)
      LK_IDLE: begin
        d.lk = LK_IDLE;
      end
      LK_SEND: begin
        if (li_ready && !sess) begin
          d.lk = LK_WAIT;
        end
      end
      LK_WAIT: begin
        if (li_done) begin
          d.lk = LK_IDLE;
        end
      end
      default: begin
        d.lk = LK_IDLE;
      end
    endcase

    // Supervisory source is served first when both arrive together.
    rs = lici_gate(scada_cmd, 1'b1, sw, sess, lev_any, q.ctrl[CTL_TRIP_ALW], q.ctrl[CTL_PNL_OVR]);
    rp = lici_gate(panel_cmd, 1'b0, sw, sess, lev_any, q.ctrl[CTL_TRIP_ALW], q.ctrl[CTL_PNL_OVR]);
    if (scada_valid) begin
      if (rs != RSN_NONE) begin
        d.s_rej = 1'b1;
        d.s_rsn = rs;
      end else if (scada_cmd.kind == KIND_DUMMY && (busy || sess)) begin
        d.s_ack = 1'b1;
      end else if (busy) begin
        d.s_rej = 1'b1;
        d.s_rsn = RSN_BUSY;
      end else begin
        d.s_ack = 1'b1;
        grabbed = 1'b1;
        d.out = scada_cmd;
      end
    end
    if (panel_valid) begin
      if (rp != RSN_NONE) begin
        d.p_rej = 1'b1;
        d.p_rsn = rp;
      end else if (busy || grabbed) begin
        d.p_rej = 1'b1;
        d.p_rsn = RSN_BUSY;
      end else begin
        d.p_ack = 1'b1;
        grabbed = 1'b1;
        d.out = panel_cmd;
      end
    end
    ev[IRQ_SREJ] = d.s_rej;
    ev[IRQ_PREJ] = d.p_rej;

    // Effects of a forwarded command on tracked mode and arming.
    if (grabbed) begin
      d.lk = LK_SEND;
      if (d.out.kind == KIND_MODE) begin
        d.mode[d.out.target] = d.out.mode;
      end
      if (d.out.kind == KIND_ARM_ON) begin
        d.armed = 1'b1;
        d.atmr = '0;
      end
      if (d.out.kind == KIND_ARM_OFF) begin
        d.armed = 1'b0;
      end
    end else if (q.armed && q.alim != '0) begin
      if (q.atmr >= q.alim - 32'h1) begin
        d.armed = 1'b0;
        ev[IRQ_ARM_EXP] = 1'b1;
      end else begin
        d.atmr = q.atmr + 32'h1;
      end
    end

    // Lever edges force the policy mode and later restore the previous one.
    for (int i = 0; i < NUM_LI; i++) begin
      if (nf[SYN_LV+i] && !q.f[SYN_LV+i]) begin
        d.saved[i] = d.mode[i];
        d.mode[i] = lici_mode_t'(q.ctrl[CTL_POL_LSB +: 3]);
        ev[IRQ_LEVER] = 1'b1;
      end else if (!nf[SYN_LV+i] && q.f[SYN_LV+i]) begin
        d.mode[i] = q.saved[i];
        ev[IRQ_LEVER] = 1'b1;
      end
    end

    // Register writes: address and data may come in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_h = 1'b1;
      d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_h = 1'b1;
      d.wd = s_axi_wdata;
      d.ws = s_axi_wstrb;
    end
    aw_ok = d.aw_h;
    w_ok = d.w_h;
    if (aw_ok && w_ok) begin
      d.aw_h = 1'b0;
      d.w_h = 1'b0;
      d.bv = 1'b1;
      d.br = RESP_OKAY;
      unique case (d.awa)
        REG_CTRL: d.ctrl = lici_merge(q.ctrl, d.wd, d.ws) & CTRL_MASK;
        REG_ARM_LIMIT: d.alim = lici_merge(q.alim, d.wd, d.ws);
        REG_IRQ_STATUS: begin
          if (d.ws[0]) begin
            d.ist = q.ist & ~d.wd[IRQ_W-1:0];
          end
        end
        REG_IRQ_MASK: begin
          if (d.ws[0]) begin
            d.imsk = d.wd[IRQ_W-1:0];
          end
        end
        REG_STATUS, REG_MODES: d.br = RESP_OKAY; // Read-only registers ignore writes.
        default: d.br = RESP_SLVERR;
      endcase
    end
    if (q.bv && s_axi_bready) begin
      d.bv = 1'b0;
    end
    // A new event wins over a clear in the same cycle.
    d.ist = d.ist | ev;

    // Register reads.
    if (q.rv && s_axi_rready) begin
      d.rv = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rv = 1'b1;
      d.rr = RESP_OKAY;
      d.rd = '0;
      unique case (s_axi_araddr)
        REG_CTRL: d.rd = q.ctrl;
        REG_ARM_LIMIT: d.rd = q.alim;
        REG_STATUS: begin
          d.rd[STA_SWITCH] = sw;
          d.rd[STA_SESSION] = sess;
          d.rd[STA_LEVER] = lev_any;
          d.rd[STA_ARMED] = q.armed;
          d.rd[STA_BUSY] = busy;
          d.rd[STA_ETH] = eth_en;
        end
        REG_IRQ_STATUS: d.rd[IRQ_W-1:0] = q.ist;
        REG_IRQ_MASK: d.rd[IRQ_W-1:0] = q.imsk;
        REG_MODES: d.rd[3*NUM_LI-1:0] = q.mode;
        default: d.rr = RESP_SLVERR;
      endcase
    end
  end

  // State register; the enable freezes everything, reset does not wait for it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.alim <= ARM_LIMIT_RST;
      q.ist <= IRQ_RST;
      q.imsk <= IRQ_RST;
      q.lk <= LK_IDLE;
    end else if (ce) begin
      q <= d;
    end
  end

  // Handshakes; the bus stalls while a response waits so only one of each is in flight.
  assign s_axi_awready = ce && !q.aw_h && !q.bv;
  assign s_axi_wready = ce && !q.w_h && !q.bv;
  assign s_axi_bvalid = q.bv;
  assign s_axi_bresp = q.br;
  assign s_axi_arready = ce && !q.rv;
  assign s_axi_rvalid = q.rv;
  assign s_axi_rdata = q.rd;
  assign s_axi_rresp = q.rr;
  assign scada_ready = ce;
  assign panel_ready = ce;
  assign scada_ack = q.s_ack;
  assign scada_rej = q.s_rej;
  assign scada_rsn = q.s_rsn;
  assign panel_ack = q.p_ack;
  assign panel_rej = q.p_rej;
  assign panel_rsn = q.p_rsn;

  // A session holds back the pending command rather than dropping it.
  assign li_valid = q.lk == LK_SEND && !sess;
  assign li_cmd = q.out;
  assign li_mode = q.mode;
  assign armed = q.armed;
  assign ev_fetch_en = !sess;
  assign ev_collect_all = q.collect;
  assign not_in_session = sess;

  // Ethernet can only be chosen when supported, and never together with serial.
  assign eth_en = ETH_SUPPORTED && q.ctrl[CTL_ETH_SEL];
  assign serial_en = !eth_en;
  assign irq = |(q.ist & q.imsk);
endmodule

/* File: sim/lici_li_model.sv */
// Behavioural model of the linked line interrupters on the command link.
// Assumes one clock; dly slows completion and hold stalls it for busy tests.
`timescale 1ns/10ps
module lici_li_model (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset, active low.
  input wire logic li_valid, // Command offered.
  input wire logic [3:0] dly, // Completion delay in cycles.
  input wire logic hold, // Stall completion while high.
  output logic li_ready, // Command taken.
  output logic li_done, // Command finished, pulse.
  output logic pend // Command under way.
);
  logic [3:0] cnt_q;
  // Take one command, then finish it late, so the link stays busy for a while.
  always @(posedge aclk) begin
    li_done <= 1'h0;
    if (!aresetn) begin
      li_ready <= 1'h0;
      pend <= 1'h0;
      cnt_q <= 4'h0;
    end else if (li_valid && li_ready) begin
      li_ready <= 1'h0;
      pend <= 1'h1;
      cnt_q <= dly;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (pend && !hold) begin
      pend <= 1'h0;
      li_done <= 1'h1;
    end else if (li_valid && !pend) begin
      li_ready <= 1'h1;
    end
  end
endmodule

/* File: sim/lici_interlock_properties.sv */
// Checker of source answers, link gating and radio choice of the interlock.
// Assumes ce is held high and the checker is bound to every interlock.
`timescale 1ns/10ps
module lici_interlock_chk #(
  parameter int NUM_LI = 3
) (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset, active low.
  input wire lici_pkg::lici_cmd_t scada_cmd, // Supervisory command.
  input wire logic scada_valid, // Command valid.
  input wire logic scada_ack, // Accept pulse.
  input wire logic scada_rej, // Reject pulse.
  input wire lici_pkg::lici_rsn_t scada_rsn, // Reject reason.
  input wire logic panel_valid, // Panel valid.
  input wire logic panel_ack, // Panel accept.
  input wire logic [NUM_LI-1:0] lever_down_pin, // Levers.
  input wire logic li_valid, // Link command valid.
  input wire logic ev_fetch_en, // Event retrieval on.
  input wire logic ev_collect_all, // Collect pulse.
  input wire logic not_in_session, // Session point.
  input wire logic serial_en, // Serial radio on.
  input wire logic eth_en // Ethernet radio on.
);
  import lici_pkg::*;
  logic s_ok;
  logic s_real;
  // Well-formed supervisory controls; dummies are kept apart because they always pass.
  assign s_ok = scada_valid && scada_cmd.target < NUM_LI && scada_cmd.mode <= MODE_FAST;
  assign s_real = s_ok && scada_cmd.kind <= KIND_ARM_OFF;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_radio; !(serial_en && eth_en); endproperty
  a_radio: assert property (p_radio) else $error("two radios on");
  property p_eth; !eth_en; endproperty
  a_eth: assert property (p_eth) else $error("ethernet on");
  property p_dummy; s_ok && scada_cmd.kind == KIND_DUMMY |=> scada_ack; endproperty
  a_dummy: assert property (p_dummy) else $error("dummy refused");
  property p_sess_out; not_in_session |-> !li_valid && !ev_fetch_en; endproperty
  a_sess_out: assert property (p_sess_out) else $error("link used in session");
  property p_sess_rej; s_real && not_in_session |=> scada_rej && scada_rsn == RSN_SESSION;
  endproperty
  a_sess_rej: assert property (p_sess_rej) else $error("session not refused");
  property p_collect; $fell(not_in_session) |-> ##[0:1] ev_collect_all; endproperty
  a_collect: assert property (p_collect) else $error("no collect");
  property p_lever; (|lever_down_pin)[*5] ##0 (s_real && !not_in_session) |=> scada_rej;
  endproperty
  a_lever: assert property (p_lever) else $error("lever not refused");
  property p_busy; li_valid && scada_valid && scada_cmd.kind == KIND_MODE |=> !scada_ack;
  endproperty
  a_busy: assert property (p_busy) else $error("mode taken while busy");
  property p_answer; scada_valid |=> scada_ack != scada_rej; endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_one; scada_valid && panel_valid |=> !(scada_ack && panel_ack); endproperty
  a_one: assert property (p_one) else $error("two accepted");
endmodule

bind lici_interlock lici_interlock_chk #(.NUM_LI(NUM_LI)) i_chk (.aclk, .aresetn,
  .scada_cmd, .scada_valid, .scada_ack, .scada_rej, .scada_rsn, .panel_valid, .panel_ack,
  .lever_down_pin, .li_valid, .ev_fetch_en, .ev_collect_all, .not_in_session, .serial_en,
  .eth_en);

/* File: sim/line_interrupter_control_interlock_tb.sv */
// Bench of the interlock: register bus, both sources, pins and the link model.
// Assumes package, design, checker and link model are compiled before it.
`timescale 1ns/10ps
module line_interrupter_control_interlock_tb;
  import lici_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic ce = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic rc_switch_pin = 1'h0, pc_session_pin = 1'h0, hold = 1'h0, ea = 1'h0;
  logic [2:0] lever_down_pin = 3'h0;
  logic [3:0] dly = 4'h0;
  lici_cmd_t scada_cmd = '0, panel_cmd = '0, li_cmd, c;
  logic scada_valid = 1'h0, panel_valid = 1'h0, scada_ready, scada_ack, scada_rej;
  logic panel_ready, panel_ack, panel_rej, li_valid, li_ready, li_done, pend, armed;
  logic ev_fetch_en, ev_collect_all, not_in_session, serial_en, eth_en, irq;
  lici_rsn_t scada_rsn, panel_rsn, er;
  logic [8:0] li_mode;
  logic [31:0] ctl = 32'h0;
  logic [1:0] src;
  lici_mode_t em [3] = '{default: MODE_NORMAL};
  int seed = 56610;
  int n_errors = 0;
  int checks_done = 0;

  lici_interlock #(.NUM_LI(3)) i_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rc_switch_pin, .pc_session_pin,
    .lever_down_pin, .scada_cmd, .scada_valid, .scada_ready, .scada_ack, .scada_rej,
    .scada_rsn, .panel_cmd, .panel_valid, .panel_ready, .panel_ack, .panel_rej, .panel_rsn,
    .li_cmd, .li_valid, .li_ready, .li_done, .li_mode, .armed, .ev_fetch_en, .ev_collect_all,
    .not_in_session, .serial_en, .eth_en, .irq);
  lici_li_model i_li (.aclk, .aresetn, .li_valid, .dly, .hold, .li_ready, .li_done, .pend);

  // Free-running 25 MHz clock.
  always #20 aclk = ~aclk;

  task automatic give_verdict();
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Bus handshakes are judged at the falling edge, where ready and valid are settled.
  // Response readies stay high between transfers; each call drives them high again at its start.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      if (s_axi_bvalid) chk("bresp", RESP_OKAY, s_axi_bresp);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      if (s_axi_rvalid) chk("rdata", e, s_axi_rdata);
      if (s_axi_rvalid) chk("rresp", er, s_axi_rresp);
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
  endtask

  // One-cycle control from scada (bit 0) and/or panel (bit 1), answer checked next cycle.
  task automatic cmd(input logic [1:0] s, input lici_kind_t k, input logic [1:0] t,
      input lici_mode_t m, input lici_rsn_t es, input lici_rsn_t ep);
    lici_rsn_t e;
    scada_cmd <= {k, t, m};
    panel_cmd <= {k, t, m};
    scada_valid <= s[0];
    panel_valid <= s[1];
    @(posedge aclk);
    scada_valid <= 1'h0;
    panel_valid <= 1'h0;
    #1;
    for (int i = 0; i < 2; i++) begin
      e = i ? ep : es;
      if (s[i]) begin
        chk("ack", e == RSN_NONE, i ? panel_ack : scada_ack);
        chk("rej", e != RSN_NONE, i ? panel_rej : scada_rej);
        if (e != RSN_NONE) chk("rsn", e, i ? panel_rsn : scada_rsn);
      end
    end
    @(posedge aclk);
  endtask

  // The link is idle once nothing is offered, pending or finishing.
  task automatic idle();
    forever begin
      @(negedge aclk);
      if (!pend && !li_done && !li_valid) break;
    end
    @(posedge aclk);
  endtask

  // Expected reason for a control with the switch pin and control bits as currently driven.
  function automatic lici_rsn_t f_rsn(input logic p, input lici_cmd_t x);
    if (p && x.kind >= KIND_ARM_ON) return RSN_BAD;
    if (!p && x.kind == KIND_DUMMY) return RSN_NONE;
    if (p ? (rc_switch_pin && !ctl[CTL_PNL_OVR]) :
        (!rc_switch_pin && !(ctl[CTL_TRIP_ALW] && x.kind == KIND_TRIP)))
      return RSN_SWITCH;
    return RSN_NONE;
  endfunction

  // Watchdog far beyond the expected run length.
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end

  // Reset, registers, interrupt, random controls, then busy, session, lever and arming.
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rdc(REG_CTRL, CTRL_RST, RESP_OKAY);
    rdc(REG_ARM_LIMIT, ARM_LIMIT_RST, RESP_OKAY);
    rdc(REG_IRQ_MASK, 32'h0, RESP_OKAY);
    rdc(8'h18, 32'h0, RESP_SLVERR);
    wr(REG_CTRL, 32'h4);
    chk("radios", 2'h1, {eth_en, serial_en});
    chk("ready", 2'h3, {scada_ready, panel_ready});
    wr(REG_IRQ_MASK, 32'h1);
    cmd(2'h1, KIND_TRIP, 2'h0, MODE_NORMAL, RSN_SWITCH, RSN_NONE);
    chk("irq", 1'h1, irq);
    wr(REG_IRQ_MASK, 32'h0);
    chk("irq", 1'h0, irq);
    wr(REG_IRQ_MASK, 32'h1);
    chk("irq", 1'h1, irq);
    wr(REG_IRQ_STATUS, 32'h1);
    chk("irq", 1'h0, irq);
    for (int n = 0; n < 40; n++) begin
      c.kind = lici_kind_t'({$random(seed)} % 6);
      c.target = {$random(seed)} % 3;
      c.mode = lici_mode_t'({$random(seed)} % 5);
      rc_switch_pin <= $random(seed);
      dly <= {$random(seed)} % 4;
      ctl = {$random(seed)} % 4;
      src = 2'h1 + {$random(seed)} % 2;
      wr(REG_CTRL, ctl);
      repeat (4) @(posedge aclk);
      er = f_rsn(src[1], c);
      cmd(src, c.kind, c.target, c.mode, er, er);
      if (er == RSN_NONE && c.kind == KIND_MODE) em[c.target] = c.mode;
      if (er == RSN_NONE && c.kind == KIND_ARM_ON) ea = 1'h1;
      if (er == RSN_NONE && c.kind == KIND_ARM_OFF) ea = 1'h0;
      idle();
      chk("li_mode", {em[2], em[1], em[0]}, li_mode);
      chk("armed", ea, armed);
      if (er == RSN_NONE) chk("li_cmd", c, li_cmd);
    end
    rc_switch_pin <= 1'h1;
    wr(REG_CTRL, 32'h0);
    repeat (4) @(posedge aclk);
    hold <= 1'h1;
    cmd(2'h1, KIND_MODE, 2'h0, MODE_FAST, RSN_NONE, RSN_NONE);
    em[0] = MODE_FAST;
    cmd(2'h1, KIND_MODE, 2'h1, MODE_PROT_OFF, RSN_BUSY, RSN_NONE);
    hold <= 1'h0;
    idle();
    wr(REG_CTRL, 32'h2);
    cmd(2'h3, KIND_MODE, 2'h1, MODE_FAST_SINGLE, RSN_NONE, RSN_BUSY);
    em[1] = MODE_FAST_SINGLE;
    idle();
    chk("li_mode", {em[2], em[1], em[0]}, li_mode);
    pc_session_pin <= 1'h1;
    repeat (5) @(posedge aclk);
    chk("session", 2'h1, {ev_fetch_en, not_in_session});
    rdc(REG_STATUS, {28'h0, ea, 3'h3}, RESP_OKAY);
    rdc(REG_MODES, {23'h0, em[2], em[1], em[0]}, RESP_OKAY);
    cmd(2'h3, KIND_TRIP, 2'h2, MODE_NORMAL, RSN_SESSION, RSN_SESSION);
    chk("li_valid", 1'h0, li_valid);
    pc_session_pin <= 1'h0;
    for (int k = 0; k < 8 && ev_collect_all !== 1'h1; k++) @(negedge aclk);
    chk("collect", 1'h1, ev_collect_all);
    @(posedge aclk);
    wr(REG_CTRL, 32'h12);
    lever_down_pin <= 3'h2;
    repeat (5) @(posedge aclk);
    chk("lever", {em[2], MODE_PROT_OFF, em[0]}, li_mode);
    cmd(2'h3, KIND_MODE, 2'h0, MODE_NORMAL, RSN_LEVER, RSN_LEVER);
    lever_down_pin <= 3'h0;
    repeat (4) @(posedge aclk);
    idle();
    chk("restore", {em[2], em[1], em[0]}, li_mode);
    wr(REG_ARM_LIMIT, 32'ha);
    cmd(2'h1, KIND_ARM_ON, 2'h0, MODE_NORMAL, RSN_NONE, RSN_NONE);
    repeat (5) @(posedge aclk);
    chk("armed", 1'h1, armed);
    repeat (10) @(posedge aclk);
    chk("expired", 1'h0, armed);
    give_verdict();
  end
endmodule
